// ===== dv/adc_frame_command_alarm_programmer_tb_top.sv
`timescale 1ns/1ps
module adc_frame_command_alarm_programmer_tb_top
	import afcap_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, rv = 1'b0, ce = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, e;
	logic [11:0] res = 12'h000;
	logic [15:0] ow = 16'h0000;
	wire logic [31:0] dat_o;
	wire logic ack, cs_n, sclk, serial_command_in, in_seq, ocv, irq;
	wire logic [3:0] chan;
	wire logic [15:0] ocw;
	int err_total = 0, tests_run = 0, cyc_cnt = 0, ocv_cnt = 0, ocv_exp = 0;
	int hi[16], lo[16], ch = 0, grp = 0, mseq = 0, mode = 0;

	afcap_top uut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .cs_n_i(cs_n), .sclk_i(sclk), .serial_command_in_i(serial_command_in),
		.result_i(res), .result_valid_i(rv), .chan_o(chan), .in_seq_o(in_seq),
		.other_cmd_valid_o(ocv), .other_cmd_word_o(ocw), .irq_o(irq));
	afcap_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_command_in));

	// Clock, 50 ns period
	initial
	begin
		forever #25 clk = ~clk;
	end

	// Hang guard and pulse counter
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (ocv === 1'b1) ocv_cnt++;
		if (cyc_cnt == 40000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// All threshold registers against the model
	task automatic chk_thr();
		for (int i = 0; i < 16; i++)
		begin
			wb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
			check(rd, {6'h00, 10'(lo[i]), 6'h00, 10'(hi[i])});
		end
	endtask

	// Send one frame and advance the reference model
	task automatic frame(input logic [15:0] w);
		host.send(w, 16);
		if (mseq != 0)
		begin
			if (w[13]) hi[{grp[1:0], w[15:14]}] = w[9:0];
			else lo[{grp[1:0], w[15:14]}] = w[9:0];
			mseq = !w[12];
		end
		else if (w[15:14] == 2'b11)
		begin
			mseq = 1;
			grp = w[13:12];
		end
		else if (w[15:12] != 4'h0)
		begin
			ocv_exp++;
			ow = w;
		end
		if (mode == 1) ch = (ch + 1) % 16;
		if (mode == 2) ch = (ch == 2) ? 0 : ch + 1;
		check(chan, ch);
		check(in_seq, mseq);
		check(ocv_cnt, ocv_exp);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			hi[i] = 'h3FF;
			lo[i] = 0;
		end
		void'($urandom(32'h2706CCFE));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk_thr();
		wb(1'b0, 8'h04, 32'h0);
		check(rd, 32'h0);
		// Continue code in manual, auto1, auto2 (last channel 2)
		for (int m = 0; m < 3; m++)
		begin
			wb(1'b1, 8'h00, 32'h80 | 32'(m));
			mode = m;
			ch = 0;
			repeat (4) frame({4'h0, 12'($urandom)});
		end
		wb(1'b1, 8'h00, 32'h80);
		mode = 0;
		ch = 0;
		frame({4'h4, 12'($urandom)});
		check(ocw, ow);
		// Full load of every group
		for (int g = 0; g < 4; g++)
		begin
			frame(host.entry(2'(g)) | 16'(12'($urandom)));
			for (int k = 0; k < 8; k++)
				frame(host.load(3'(k), 1'(k == 7), 10'($urandom)));
			chk_thr();
		end
		// Partial load, look-alike words taken as thresholds
		frame(host.entry(2'($urandom)));
		frame(16'h4000 | 16'(10'($urandom)));
		frame(16'h0000);
		frame(host.load(3'b110, 1'b1, 10'($urandom)));
		frame(16'h0000);
		chk_thr();
		// Short frame is dropped
		wb(1'b1, 8'h08, 32'hF);
		host.send(16'hC000, 15);
		wb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h4);
		check(in_seq, 1'b0);
		// Alarms on channel 0, interrupt masked and unmasked
		for (int k = 0; k < 6; k++)
		begin
			wb(1'b1, 8'h0C, {30'h0, 1'(k), 1'b0});
			wb(1'b1, 8'h10, 32'hFFFFFFFF);
			wb(1'b1, 8'h08, 32'hF);
			@(posedge clk);
			res <= (k < 2 || k == 5) ? 12'hFFF : (k < 4) ? 12'h000 : 12'($urandom);
			rv <= 1'b1;
			ce <= (k != 5); // Last pass: frozen block must miss the result
			@(posedge clk);
			rv <= 1'b0;
			ce <= 1'b1;
			repeat (3) @(posedge clk);
			e = (32'(res[11:2] < lo[0]) << 16) | 32'(res[11:2] > hi[0]);
			if (k == 5) e = 32'h0;
			check(irq, 1'(k) && e != 0);
			wb(1'b0, 8'h10, 32'h0);
			check(rd, e);
		end
		wb(1'b1, 8'h08, 32'hF);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		give_verdict();
	end
endmodule

// ===== dv/afcap_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial host model
// ----------------------------------------
module afcap_host_model
(
	input wire logic clk_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	// Idle: deselected, clock parked high
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		sdi_o = 1'b0;
	end

	// One frame of nb bits, MSB first, data set while clock low
	task automatic send(input logic [15:0] w, input int nb);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 15; i > 15 - nb; i--)
		begin
			sclk_o <= 1'b0;
			sdi_o <= w[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o; // Released line shows no stale bit
		repeat (8) @(posedge clk_i);
	endtask

	// Entry word: 11 then group number
	function automatic logic [15:0] entry(input logic [1:0] g);
		return {2'b11, g, 12'h000};
	endfunction

	// Loading word: channel low bits, limit select, exit, threshold
	function automatic logic [15:0] load(input logic [2:0] k, input logic ex,
		input logic [9:0] t);
		return {k[1:0], k[2], ex, 2'b00, t};
	endfunction
endmodule

// ===== logic/afcap_limit_cmp.sv
`timescale 1ns/1ps
module afcap_limit_cmp
	import afcap_pkg::*;
(
	input wire logic [RES_W-1:0] result_i,
	input wire logic [THR_W-1:0] hi_thr_i,
	input wire logic [THR_W-1:0] lo_thr_i,
	output logic hi_hit_o,
	output logic lo_hit_o
);
	logic [THR_W-1:0] upper;

	// Upper ten bits of the result against both limits
	assign upper = result_i[RES_W-1:RES_W-THR_W];
	assign hi_hit_o = upper > hi_thr_i;
	assign lo_hit_o = upper < lo_thr_i;
endmodule

// ===== logic/afcap_pkg.sv
package afcap_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NUM_CH = 16;
	localparam int CH_W = 4;
	localparam int GRP_SIZE = 4;
	localparam int NUM_GROUPS = NUM_CH / GRP_SIZE;
	localparam int WORD_W = 16;
	localparam int RES_W = 12;
	localparam int THR_W = 10;
	localparam int BITCNT_W = 5;
	localparam logic [BITCNT_W-1:0] FRAME_BITS = 5'h10;

	// ----------------------------------------
	// Command word fields
	// ----------------------------------------
	localparam int CODE_HI = 15;
	localparam int CODE_LO = 12;
	localparam logic [3:0] CMD_CONTINUE = 4'h0;
	localparam logic [1:0] CMD_ALARM_PFX = 2'h3;
	localparam logic [THR_W-1:0] THR_HI_RST = 10'h3FF;
	localparam logic [THR_W-1:0] THR_LO_RST = 10'h000;

	// ----------------------------------------
	// Register map and reset values
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] REG_ALARM = 8'h10;
	localparam logic [7:0] REG_SEQ = 8'h14;
	localparam logic [1:0] REG_THR_PAGE = 2'h1;
	localparam logic [15:0] SEQ_RST = 16'hFFFF;
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_AUTO1 = 2'h1;
	localparam logic [1:0] MODE_AUTO2 = 2'h2;

	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_BADFRAME = 2;
	localparam int IRQ_EXIT = 3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] last_ch;
		logic [3:0] man_ch;
		logic [1:0] mode;
	} afcap_ctrl_t;

	typedef struct packed {
		logic [1:0] channel_low_bits_field;
		logic limit_select_bit;
		logic sequence_exit_bit;
		logic [1:0] spare;
		logic [THR_W-1:0] threshold_value_field;
	} afcap_load_t;

	typedef enum logic {ST_IDLE, ST_LOAD} afcap_state_t;

endpackage

// ===== logic/afcap_sync2.sv
`timescale 1ns/1ps
module afcap_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// Two-stage capture of asynchronous levels
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end
		else if (ce_i)
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// ===== logic/afcap_top.sv
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Operation
// - Code 0000 keeps the current mode and all settings.
// - Continue in auto modes advances the channel counter as usual.
// - Continue in manual mode keeps the last selected channel.
// - Continue ignores the twelve low bits of the word.
// - Each channel owns a high and a low threshold register.
// - Thresholds are grouped four channels, eight registers, per group.
// - Group count follows channel count: sixteen channels give four groups.
// - A full group load takes one entry frame plus eight frames.
// - Entry frame only enters; each later frame writes one threshold.
// - Partial loads are allowed, ended early by the exit bit.
// - Sequence is left at the frame carrying the first exit bit.
// - Entry code is 11 followed by a two-bit group number.
// - During loading conversion goes on; other commands are refused.
// - Top two bits give channel low bits, combined with the group.
// - Bit thirteen picks high limit when one, low limit when zero.
// - Exit bit ends the sequence; otherwise every word is a threshold.
// - Ten-bit threshold versus result top bits; high ones, low zeros.
module afcap_top
	import afcap_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic serial_command_in_i,
	input wire logic [RES_W-1:0] result_i,
	input wire logic result_valid_i,
	output logic [CH_W-1:0] chan_o,
	output logic in_seq_o,
	output logic other_cmd_valid_o,
	output logic [WORD_W-1:0] other_cmd_word_o,
	output logic irq_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic cs_n_s;
	logic sclk_s;
	logic sdi_s;
	logic sclk_d_r;
	logic cs_n_d_r;
	logic sclk_rise;
	logic frame_end;
	logic frame_start;
	logic [WORD_W-1:0] shift_r;
	logic [BITCNT_W-1:0] bitcnt_r;
	logic dec_stb_r;
	logic bad_stb_r;
	logic [WORD_W-1:0] word_r;
	logic [3:0] code;
	afcap_load_t load;
	afcap_state_t state_r;
	logic [1:0] grp_r;
	logic entry_hit;
	logic thr_we;
	logic [CH_W-1:0] tgt_ch;
	logic [THR_W-1:0] hi_thr_r [NUM_CH];
	logic [THR_W-1:0] lo_thr_r [NUM_CH];
	logic [CH_W-1:0] chan_r;
	afcap_ctrl_t ctrl_r;
	logic [15:0] seq_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [31:0] alarm_r;
	logic hi_hit;
	logic lo_hit;
	logic bus_req;
	logic bus_wr;
	logic [31:0] bmask;
	logic [31:0] rd_data;
	logic [31:0] alarm_set;

	// ----------------------------------------
	// Link pins and frame capture
	// ----------------------------------------
	afcap_sync2 #(.W(3), .RST_VAL(3'h6)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i({cs_n_i, sclk_i, serial_command_in_i}),
		.q_o({cs_n_s, sclk_s, sdi_s})
	);

	// Edge finding on the synchronised link levels
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end
		else if (ce_i)
		begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
	assign frame_end = cs_n_s & ~cs_n_d_r;
	assign frame_start = ~cs_n_s & cs_n_d_r;

	// Shift register, MSB first, and saturating bit count
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift_r <= '0;
			bitcnt_r <= '0;
		end
		else if (ce_i)
		begin
			if (frame_start)
				bitcnt_r <= '0;
			else if (sclk_rise)
			begin
				shift_r <= {shift_r[WORD_W-2:0], sdi_s};
				if (bitcnt_r != '1)
					bitcnt_r <= bitcnt_r + 5'h01;
			end
		end
	end

	// Word handed to the decoder once the frame has closed
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			dec_stb_r <= 1'b0;
			bad_stb_r <= 1'b0;
			word_r <= '0;
		end
		else if (ce_i)
		begin
			dec_stb_r <= frame_end && (bitcnt_r == FRAME_BITS);
			bad_stb_r <= frame_end && (bitcnt_r != FRAME_BITS);
			if (frame_end)
				word_r <= shift_r;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign code = word_r[CODE_HI:CODE_LO];
	assign load = afcap_load_t'(word_r);
	assign entry_hit = (code[3:2] == CMD_ALARM_PFX) && (32'(code[1:0]) < NUM_GROUPS);
	assign thr_we = dec_stb_r && (state_r == ST_LOAD);
	assign tgt_ch = {grp_r, load.channel_low_bits_field};

	// Loading sequence state and selected group
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_r <= ST_IDLE;
			grp_r <= '0;
		end
		else if (ce_i && dec_stb_r)
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (entry_hit)
					begin
						state_r <= ST_LOAD;
						grp_r <= code[1:0];
					end
				end
				ST_LOAD:
				begin
					if (load.sequence_exit_bit)
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Threshold store, two per channel, grouped by four channels
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				hi_thr_r[i] <= THR_HI_RST;
				lo_thr_r[i] <= THR_LO_RST;
			end
		end
		else if (ce_i && thr_we)
		begin
			if (load.limit_select_bit)
				hi_thr_r[tgt_ch] <= load.threshold_value_field;
			else
				lo_thr_r[tgt_ch] <= load.threshold_value_field;
		end
	end

	// Next channel for the automatic modes
	function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] cur,
		input afcap_ctrl_t c, input logic [15:0] seq);
		logic [CH_W-1:0] n;
		logic [CH_W-1:0] cand;
		logic found;
		n = cur;
		found = 1'b0;
		if (c.mode == MODE_AUTO2)
			n = (cur == c.last_ch) ? '0 : cur + 4'h1;
		else if (c.mode == MODE_AUTO1)
		begin
			for (int i = 1; i <= NUM_CH; i++)
			begin
				cand = cur + CH_W'(i);
				if (!found && seq[cand])
				begin
					n = cand;
					found = 1'b1;
				end
			end
		end
		return n;
	endfunction

	// Channel counter: in the auto modes advances every decoded frame, also while loading
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			chan_r <= '0;
		else if (ce_i)
		begin
			if (bus_wr && wb_adr_i == REG_CTRL && wb_sel_i[0])
				chan_r <= '0;
			else if (dec_stb_r)
				chan_r <= next_chan(chan_r, ctrl_r, seq_r);
		end
	end

	// Commands outside this block, refused while loading
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			other_cmd_valid_o <= 1'b0;
			other_cmd_word_o <= '0;
		end
		else if (ce_i)
		begin
			other_cmd_valid_o <= dec_stb_r && (state_r == ST_IDLE) && !entry_hit
				&& (code != CMD_CONTINUE);
			if (dec_stb_r && state_r == ST_IDLE)
				other_cmd_word_o <= word_r;
		end
	end

	// ----------------------------------------
	// Alarm comparison
	// ----------------------------------------
	afcap_limit_cmp u_cmp (
		.result_i(result_i),
		.hi_thr_i(hi_thr_r[chan_r]),
		.lo_thr_i(lo_thr_r[chan_r]),
		.hi_hit_o(hi_hit),
		.lo_hit_o(lo_hit)
	);

	always_comb
	begin
		alarm_set = '0;
		if (result_valid_i)
		begin
			alarm_set[chan_r] = hi_hit;
			alarm_set[5'(NUM_CH) + 5'(chan_r)] = lo_hit;
		end
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && ce_i; // Lands with ack
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Software controlled configuration
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl_r <= '0;
			seq_r <= SEQ_RST;
			irq_mask_r <= '0;
		end
		else if (bus_wr)
		begin
			if (wb_adr_i == REG_CTRL)
				ctrl_r <= afcap_ctrl_t'(10'((32'(ctrl_r) & ~bmask) | (wb_dat_i & bmask)));
			else if (wb_adr_i == REG_SEQ)
				seq_r <= 16'((32'(seq_r) & ~bmask) | (wb_dat_i & bmask));
			else if (wb_adr_i == REG_IRQ_MASK)
				irq_mask_r <= IRQ_W'((32'(irq_mask_r) & ~bmask) | (wb_dat_i & bmask));
		end
	end

	// Sticky event bits; a new event wins over a clearing write
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			irq_stat_r <= '0;
			alarm_r <= '0;
		end
		else if (ce_i)
		begin
			if (bus_wr && wb_adr_i == REG_IRQ_STAT)
				irq_stat_r <= irq_stat_r & ~IRQ_W'(wb_dat_i & bmask);
			if (dec_stb_r)
				irq_stat_r[IRQ_FRAME] <= 1'b1;
			if (bad_stb_r)
				irq_stat_r[IRQ_BADFRAME] <= 1'b1;
			if (thr_we && load.sequence_exit_bit)
				irq_stat_r[IRQ_EXIT] <= 1'b1;
			if (|alarm_set)
				irq_stat_r[IRQ_ALARM] <= 1'b1;
			if (bus_wr && wb_adr_i == REG_ALARM)
				alarm_r <= (alarm_r & ~(wb_dat_i & bmask)) | alarm_set;
			else
				alarm_r <= alarm_r | alarm_set;
		end
	end

	// Read multiplexer
	always_comb
	begin
		rd_data = '0;
		if (wb_adr_i == REG_CTRL)
			rd_data = 32'(ctrl_r);
		else if (wb_adr_i == REG_STATUS)
			rd_data = {25'h0, grp_r, state_r == ST_LOAD, chan_r};
		else if (wb_adr_i == REG_IRQ_STAT)
			rd_data = 32'(irq_stat_r);
		else if (wb_adr_i == REG_IRQ_MASK)
			rd_data = 32'(irq_mask_r);
		else if (wb_adr_i == REG_ALARM)
			rd_data = alarm_r;
		else if (wb_adr_i == REG_SEQ)
			rd_data = 32'(seq_r);
		else if (wb_adr_i[7:6] == REG_THR_PAGE && wb_adr_i[1:0] == 2'h0)
			rd_data = {6'h0, lo_thr_r[wb_adr_i[5:2]], 6'h0, hi_thr_r[wb_adr_i[5:2]]};
	end

	// One-cycle answer, dropped in the following cycle
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= rd_data;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			irq_o <= 1'b0;
			chan_o <= '0;
			in_seq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_o <= |(irq_stat_r & irq_mask_r);
			chan_o <= chan_r;
			in_seq_o <= (state_r == ST_LOAD);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_cont_manual;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && dec_stb_r && ctrl_r.mode == MODE_MANUAL && !bus_wr |=> $stable(chan_r);
	endproperty
	a_cont_manual: assert property (p_cont_manual) else $error("manual channel moved");

	property p_cont_auto2;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && dec_stb_r && ctrl_r.mode == MODE_AUTO2 && !bus_wr && chan_r == ctrl_r.last_ch
		|=> chan_r == 4'h0;
	endproperty
	a_cont_auto2: assert property (p_cont_auto2) else $error("auto2 wrap missed");

	property p_cont_idle;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && dec_stb_r && state_r == ST_IDLE && code == CMD_CONTINUE
		|=> state_r == ST_IDLE && !other_cmd_valid_o;
	endproperty
	a_cont_idle: assert property (p_cont_idle) else $error("continue changed state");

	property p_entry;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && dec_stb_r && state_r == ST_IDLE && code[3:2] == CMD_ALARM_PFX
		|=> state_r == ST_LOAD && grp_r == $past(code[1:0]) ##1 in_seq_o || !ce_i;
	endproperty
	a_entry: assert property (p_entry) else $error("entry frame not taken");

	property p_write_only_load;
		@(posedge clk_i) disable iff (!rstn_i)
		state_r == ST_IDLE |=> $stable(hi_thr_r[tgt_ch]) || $past(bus_wr) || !$past(ce_i)
			|| $past(tgt_ch) != tgt_ch;
	endproperty
	a_write_only_load: assert property (p_write_only_load) else $error("write while idle");

	property p_thr_write;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && thr_we && load.limit_select_bit
		|=> hi_thr_r[$past(tgt_ch)] == $past(load.threshold_value_field);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("high limit not written");

	property p_exit;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && thr_we && load.sequence_exit_bit |=> state_r == ST_IDLE;
	endproperty
	a_exit: assert property (p_exit) else $error("exit bit ignored");

	property p_stay;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && thr_we && !load.sequence_exit_bit |=> state_r == ST_LOAD;
	endproperty
	a_stay: assert property (p_stay) else $error("left sequence without exit");

	property p_refuse;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && thr_we |=> !other_cmd_valid_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("command passed while loading");

	property p_alarm;
		@(posedge clk_i) disable iff (!rstn_i)
		ce_i && result_valid_i && result_i[RES_W-1:RES_W-THR_W] > hi_thr_r[chan_r]
		|=> alarm_r[$past(chan_r)] ##1 irq_stat_r[IRQ_ALARM] || !ce_i;
	endproperty
	a_alarm: assert property (p_alarm) else $error("high alarm not flagged");

endmodule
